// *** hdl/fpr_cmd.sv ***
// Power-down, reset and terminate command interpreter of the serial flash
`timescale 1ns/1ps
`default_nettype none
module fpr_cmd (
  input  wire logic clock,
  input  wire logic nrst,
  input  wire logic sclk,
  input  wire logic cs_n,
  input  wire logic si,
  input  wire logic power_down_select,
  input  wire logic terminate_permit,
  input  wire logic busy_flag,
  output var  logic so,
  output var  logic so_oe,
  output var  logic device_busy,
  output var  logic deep_low_power_state,
  output var  logic ultra_low_power_state,
  output var  logic soft_reset,
  output var  logic sram_clear,
  output var  logic terminate_op
);
  import fpr_pkg::*;

  // ************************************************************
  // Pin synchronisers and edge detection
  // ************************************************************
  fpr_link_type s1_q, s2_q, s3_q;
  logic         sclk_rise, sclk_fall, cs_rise;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      s1_q <= '{sclk: 1'b0, cs_n: 1'b1, si: 1'b0};
      s2_q <= '{sclk: 1'b0, cs_n: 1'b1, si: 1'b0};
      s3_q <= '{sclk: 1'b0, cs_n: 1'b1, si: 1'b0};
    end else begin
      s1_q <= '{sclk: sclk, cs_n: cs_n, si: si};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign sclk_rise = s2_q.sclk & ~s3_q.sclk & ~s2_q.cs_n;
  assign sclk_fall = ~s2_q.sclk & s3_q.sclk & ~s2_q.cs_n;
  assign cs_rise   = s2_q.cs_n & ~s3_q.cs_n;

  // ************************************************************
  // Frame shifter and identifier output
  // ************************************************************
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [7:0]       op_q, op_d, cf_q, cf_d;
  fpr_stage_type    stage_q, stage_d;
  logic             id_q, id_d, so_q, so_d, oe_q, oe_d;
  logic             id_allowed, aligned;
  fpr_mode_type     mode_q, mode_d;

  assign id_allowed = (mode_q == MD_STANDBY) || (mode_q == MD_DEEP);
  assign aligned    = (cnt_q[2:0] == BYTE_FIRST) && (stage_q != ST_OPCODE);

  always_comb begin
    cnt_d   = cnt_q;
    op_d    = op_q;
    cf_d    = cf_q;
    stage_d = stage_q;
    id_d    = id_q;
    so_d    = so_q;
    oe_d    = oe_q;
    if (s2_q.cs_n) begin
      cnt_d   = '0;
      stage_d = ST_OPCODE;
      id_d    = 1'b0;
      oe_d    = 1'b0;
    end else begin
      if (sclk_rise) begin
        cnt_d = cnt_q + 6'h01;
        if (stage_q == ST_OPCODE) begin
          op_d = {op_q[6:0], s2_q.si}; // RL1
        end else if (stage_q == ST_CONFIRM) begin
          cf_d = {cf_q[6:0], s2_q.si}; // RL21
        end
        if (cnt_q[2:0] == BYTE_LAST_BIT && stage_q != ST_BEYOND) begin
          stage_d = (stage_q == ST_OPCODE) ? ST_CONFIRM : ST_BEYOND;
        end
        if (cnt_q == ID_START_BIT && op_q == OP_WAKE && id_allowed) begin
          id_d = 1'b1; // RL2
        end
      end
      if (sclk_fall && id_q) begin
        so_d = DEVICE_ID[BYTE_LAST_BIT - cnt_q[2:0]]; // RL4
        oe_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      cnt_q   <= '0;
      op_q    <= 8'h00;
      cf_q    <= 8'h00;
      stage_q <= ST_OPCODE;
      id_q    <= 1'b0;
      so_q    <= 1'b0;
      oe_q    <= 1'b0;
    end else begin
      cnt_q   <= cnt_d;
      op_q    <= op_d;
      cf_q    <= cf_d;
      stage_q <= stage_d;
      id_q    <= id_d;
      so_q    <= so_d;
      oe_q    <= oe_d;
    end
  end

  assign so    = so_q;
  assign so_oe = oe_q;

  // ************************************************************
  // Power mode, reset arming and latency counter
  // ************************************************************
  logic [LAT_W-1:0] lat_q, lat_d;
  fpr_mode_type     tgt_q, tgt_d;
  logic             arm_q, arm_d, rst_q, rst_d, sram_q, sram_d, term_q, term_d;
  logic             busy_q, busy_d, deep_q, deep_d, ultra_q, ultra_d;
  logic             done;

  assign done = (lat_q == '0);

  always_comb begin
    mode_d = mode_q;
    tgt_d  = tgt_q;
    arm_d  = arm_q;
    lat_d  = done ? lat_q : lat_q - 8'h01;
    rst_d  = 1'b0;
    sram_d = 1'b0;
    term_d = 1'b0;
    unique case (mode_q)
      MD_STANDBY: begin
        if (cs_rise && aligned) begin // RL7 RL12
          arm_d = 1'b0; // RL13
          if (op_q == OP_ULTRA && !busy_flag) begin // RL10 RL11
            mode_d = MD_ENTER;
            tgt_d  = MD_ULTRA;
            lat_d  = ULTRA_ENTRY_CYC; // RL26
          end else if (op_q == OP_DEEP && !busy_flag) begin
            mode_d = MD_ENTER;
            tgt_d  = power_down_select ? MD_DEEP : MD_ULTRA; // RL8
            lat_d  = ULTRA_ENTRY_CYC;
          end else if (op_q == OP_RESET_EN) begin
            arm_d = 1'b1;
          end else if (op_q == OP_RESET && arm_q) begin
            mode_d = MD_RESET; // RL15
            rst_d  = 1'b1;
            lat_d  = SOFT_RESET_CYC;
          end else if (op_q == OP_TERMINATE && stage_q == ST_BEYOND
                       && cf_q == TERM_CONFIRM && terminate_permit) begin
            term_d = 1'b1; // RL18 RL19 RL20 RL25
          end
        end
      end
      MD_DEEP: begin
        if (cs_rise && aligned) begin
          arm_d = 1'b0;
          if (op_q == OP_WAKE) begin // RL23 RL24
            mode_d = MD_WAKE;
            lat_d  = ULTRA_WAKE_CYC;
          end else if (op_q == OP_RESET_EN) begin
            arm_d = 1'b1;
          end else if (op_q == OP_RESET && arm_q) begin
            mode_d = MD_RESET;
            rst_d  = 1'b1;
            lat_d  = SOFT_RESET_CYC;
          end
        end
      end
      MD_ULTRA: begin
        if (cs_rise && aligned && op_q == OP_WAKE) begin // RL9
          mode_d = MD_WAKE; // RL6
          rst_d  = 1'b1; // RL5
          sram_d = 1'b1;
          lat_d  = ULTRA_WAKE_CYC;
        end
      end
      MD_WAKE: begin
        if (done) begin
          mode_d = MD_STANDBY;
        end
      end
      MD_ENTER: begin
        if (done) begin
          mode_d = tgt_q;
        end
      end
      MD_RESET: begin
        arm_d = 1'b0; // RL16
        if (done) begin
          mode_d = MD_STANDBY;
        end
      end
      default: begin
        mode_d = MD_STANDBY;
      end
    endcase
    busy_d  = (mode_d == MD_WAKE) || (mode_d == MD_ENTER) || (mode_d == MD_RESET);
    deep_d  = (mode_d == MD_DEEP);
    ultra_d = (mode_d == MD_ULTRA);
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      mode_q  <= MD_STANDBY;
      tgt_q   <= MD_STANDBY;
      arm_q   <= 1'b0;
      lat_q   <= '0;
      rst_q   <= 1'b0;
      sram_q  <= 1'b0;
      term_q  <= 1'b0;
      busy_q  <= 1'b0;
      deep_q  <= 1'b0;
      ultra_q <= 1'b0;
    end else begin
      mode_q  <= mode_d;
      tgt_q   <= tgt_d;
      arm_q   <= arm_d;
      lat_q   <= lat_d;
      rst_q   <= rst_d;
      sram_q  <= sram_d;
      term_q  <= term_d;
      busy_q  <= busy_d;
      deep_q  <= deep_d;
      ultra_q <= ultra_d;
    end
  end

  assign device_busy           = busy_q;
  assign deep_low_power_state  = deep_q;
  assign ultra_low_power_state = ultra_q;
  assign soft_reset            = rst_q;
  assign sram_clear            = sram_q;
  assign terminate_op          = term_q;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  logic stable_mode;
  assign stable_mode = (mode_q == MD_STANDBY) || (mode_q == MD_DEEP) || (mode_q == MD_ULTRA);
  logic ultra_wake_seen;
  assign ultra_wake_seen = sram_q;

  chk_id_bit_order: assert property ( // RL4
    sclk_fall && id_q |=> so_q == DEVICE_ID[BYTE_LAST_BIT - $past(cnt_q[2:0])] && oe_q)
    else $error("Identifier bit out of order");
  chk_ultra_ignores: assert property ( // RL9
    mode_q == MD_ULTRA && cs_rise && op_q != OP_WAKE |=> mode_q == MD_ULTRA && !rst_q)
    else $error("Ultra state left on a non-wake opcode");
  chk_deep_filter: assert property ( // RL24
    mode_q == MD_DEEP && cs_rise && op_q != OP_WAKE && op_q != OP_RESET |=> mode_q == MD_DEEP)
    else $error("Deep state left on a filtered opcode");
  chk_odd_abort: assert property ( // RL7
    stable_mode && cs_rise && cnt_q[2:0] != BYTE_FIRST |=> mode_q == $past(mode_q) && !rst_q)
    else $error("Off-byte frame took effect");
  chk_busy_ignore: assert property ( // RL11
    mode_q == MD_STANDBY && cs_rise && op_q == OP_ULTRA && busy_flag |=> mode_q == MD_STANDBY)
    else $error("Ultra entry accepted while busy");
  chk_reset_pair: assert property ( // RL13
    soft_reset && !ultra_wake_seen |-> $past(arm_q, 1))
    else $error("Reset fired without reset enable");
  chk_reset_busy: assert property ( // RL16
    $rose(mode_q == MD_RESET) |-> (device_busy && mode_q == MD_RESET)[*8])
    else $error("Reset sequence shorter than expected");
  chk_term_gate: assert property ( // RL20
    term_q |-> $past(terminate_permit) && $past(cf_q) == TERM_CONFIRM)
    else $error("Terminate without permit or confirmation");
  chk_entry_time: assert property ( // RL26
    $rose(mode_q == MD_ENTER) |-> ##[1:80] mode_q != MD_ENTER)
    else $error("Entry latency overran");
  chk_ultra_wake_reset: assert property ( // RL5
    mode_q == MD_ULTRA && cs_rise && aligned && op_q == OP_WAKE |=> rst_q && sram_q && mode_q == MD_WAKE)
    else $error("Ultra wake without internal reset");
  chk_pd_select: assert property ( // RL8
    mode_q == MD_STANDBY && cs_rise && aligned && op_q == OP_DEEP && !busy_flag
    |=> mode_q == MD_ENTER && tgt_q == ($past(power_down_select) ? MD_DEEP : MD_ULTRA))
    else $error("Power-down target does not follow the select bit");
  chk_oe_release: assert property ( // RL4
    s2_q.cs_n |=> !oe_q && !id_q)
    else $error("Output left enabled after deselect");
  chk_wake_standby: assert property ( // RL6
    mode_q == MD_WAKE && done |=> mode_q == MD_STANDBY && !device_busy)
    else $error("Wake did not settle in standby");
  chk_term_pulse: assert property ( // RL18
    term_q |=> !term_q)
    else $error("Terminate pulse longer than one cycle");

  cov_ultra_wake: cover property ($fell(mode_q == MD_ULTRA) ##[1:100] mode_q == MD_STANDBY);
  cov_reset_pair: cover property (rst_q && mode_q == MD_RESET);
  cov_terminate:  cover property (term_q);
  cov_id_read:    cover property (oe_q ##1 $fell(oe_q));
endmodule
`default_nettype wire

// *** hdl/fpr_pkg.sv ***
// Constants, types and timing for the flash power and reset command block
// Operation
// RL1 - Opcodes arrive MSB first over eight clocks
// RL2 - Wake with identifier takes 24 dummy clocks
// RL3 - Host holds select for forty clocks minimum
// RL4 - Identifier byte repeats MSB first while selected
// RL5 - Ultra wake triggers internal reset, clears SRAM
// RL6 - Ultra wake reinitialises, then settles in standby
// RL7 - Off-byte select release aborts wake command
// RL8 - 79h, or B9h with select bit clear
// RL9 - Ultra state ignores everything except wake
// RL10 - 79h enters ultra; extra bits ignored
// RL11 - 79h ignored while program or erase busy
// RL12 - Off-byte 79h aborts; power-up in standby
// RL13 - Reset needs 66h then 99h, nothing between
// RL14 - Host releases select one clock between frames
// RL15 - Reset after 99h restores all defaults
// RL16 - No command accepted during reset sequence
// RL17 - Host checks busy and suspend before reset
// RL18 - Terminate aborts program or erase at once
// RL19 - Terminate ignores the write latch state
// RL20 - Terminate needs terminate_permit set beforehand
// RL21 - Terminate needs a following confirmation byte
// RL22 - Host uses suspend and resume to pause
// RL23 - Plain wake: release after eighth clock
// RL24 - Deep state accepts only wake and reset
// RL25 - Wrong confirmation byte cancels terminate command
// RL26 - Latencies counted from select release; busy meanwhile
package fpr_pkg;
  // ************************************************************
  // Opcodes and data values
  // ************************************************************
  localparam logic [7:0] OP_WAKE        = 8'hab;
  localparam logic [7:0] OP_DEEP        = 8'hb9;
  localparam logic [7:0] OP_ULTRA       = 8'h79;
  localparam logic [7:0] OP_RESET_EN    = 8'h66;
  localparam logic [7:0] OP_RESET       = 8'h99;
  localparam logic [7:0] OP_TERMINATE   = 8'hf0;
  localparam logic [7:0] TERM_CONFIRM   = 8'hd0;
  // Identifier value is arbitrary
  localparam logic [7:0] DEVICE_ID      = 8'h5a;

  // ************************************************************
  // Frame counting
  // ************************************************************
  localparam int unsigned CNT_W         = 6;
  localparam logic [5:0]  ID_START_BIT  = 6'h1f;
  localparam logic [2:0]  BYTE_LAST_BIT = 3'h7;
  localparam logic [2:0]  BYTE_FIRST    = 3'h0;

  // ************************************************************
  // Latencies
  // ************************************************************
  localparam int unsigned CLK_PERIOD_NS      = 40;
  localparam int unsigned ULTRA_WAKE_NS      = 3000;
  localparam int unsigned ULTRA_ENTRY_NS     = 3000;
  localparam int unsigned SOFT_RESET_NS      = 1000;
  localparam int unsigned LAT_W              = 8;
  localparam logic [7:0]  ULTRA_WAKE_CYC     = 8'((ULTRA_WAKE_NS / CLK_PERIOD_NS) - 1);
  localparam logic [7:0]  ULTRA_ENTRY_CYC    = 8'((ULTRA_ENTRY_NS / CLK_PERIOD_NS) - 1);
  localparam logic [7:0]  SOFT_RESET_CYC     = 8'((SOFT_RESET_NS / CLK_PERIOD_NS) - 1);

  // ************************************************************
  // Types
  // ************************************************************
  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic si;
  } fpr_link_type;

  typedef enum logic [1:0] {
    ST_OPCODE,
    ST_CONFIRM,
    ST_BEYOND
  } fpr_stage_type;

  typedef enum logic [2:0] {
    MD_STANDBY,
    MD_DEEP,
    MD_ULTRA,
    MD_WAKE,
    MD_ENTER,
    MD_RESET
  } fpr_mode_type;
endpackage

// *** dv/fpr_host.sv ***
// Host SPI controller model that sends command frames
`timescale 1ns/1ps
`default_nettype none
module fpr_host (
  output var  logic sclk,
  output var  logic cs_n,
  output var  logic si,
  input  wire logic so
);
  logic [15:0] rx_q = 16'h0;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si   = 1'b0;
  end
  // ****
  // One frame, mode 0, clock idle low between frames
  // ****
  task automatic frame(input logic [47:0] d, input int n);
    cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      si = d[47-i];
      #160 sclk = 1'b1;
      #160 rx_q = {rx_q[14:0], so};
      sclk = 1'b0;
    end
    #160 cs_n = 1'b1;
    si = ~si;
    #400;
  endtask
endmodule
`default_nettype wire

// *** dv/fpr_cmd_bench.sv ***
// Self-checking bench of the power and reset command block
`timescale 1ns/1ps
`default_nettype none
module fpr_cmd_bench;
  import fpr_pkg::*;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic power_down_select = 1'b1;
  logic terminate_permit = 1'b0;
  logic busy_flag = 1'b0;
  logic sclk, cs_n, si, so, so_oe, device_busy, deep_low_power_state;
  logic ultra_low_power_state, soft_reset, sram_clear, terminate_op;
  int error_cnt = 0;
  int compares = 0;
  int n_rst = 0;
  int n_clr = 0;
  int n_term = 0;
  always #20 clock = ~clock;
  fpr_cmd i_fpr_cmd (
    .clock(clock), .nrst(nrst), .sclk(sclk), .cs_n(cs_n), .si(si),
    .power_down_select(power_down_select), .terminate_permit(terminate_permit),
    .busy_flag(busy_flag), .so(so), .so_oe(so_oe), .device_busy(device_busy),
    .deep_low_power_state(deep_low_power_state), .ultra_low_power_state(ultra_low_power_state),
    .soft_reset(soft_reset), .sram_clear(sram_clear), .terminate_op(terminate_op)
  );
  fpr_host i_fpr_host (.sclk(sclk), .cs_n(cs_n), .si(si), .so(so_oe ? so : ~so));
  // ****
  // Pulse counters and helpers
  // ****
  always @(posedge clock) begin
    if (soft_reset === 1'b1) n_rst++;
    if (sram_clear === 1'b1) n_clr++;
    if (terminate_op === 1'b1) n_term++;
  end
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task st(input logic u, input logic d);
    chk("ultra", 16'(u), 16'(ultra_low_power_state));
    chk("deep", 16'(d), 16'(deep_low_power_state));
  endtask
  task close_out;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task wait_idle;
    int k;
    k = 0;
    while (device_busy !== 1'b0 && k < 300) begin
      @(posedge clock);
      #1;
      k++;
    end
    if (device_busy !== 1'b0) begin
      error_cnt++;
      close_out;
    end
  endtask
  task fr(input logic [47:0] d, input int n);
    @(posedge clock);
    #1;
    i_fpr_host.frame(d, n);
  endtask
  task op(input logic [7:0] b, input int n);
    fr({b, 40'h0}, n);
  endtask
  initial begin
    #3000000;
    error_cnt++;
    close_out;
  end
  // ****
  // Main sequence
  // ****
  initial begin
    int r;
    int c;
    logic [7:0] x;
    logic [7:0] ign [4];
    ign = '{OP_RESET_EN, OP_RESET, OP_DEEP, OP_TERMINATE};
    void'($urandom(52991));
    repeat (3) @(posedge clock);
    #1 nrst = 1'b1;
    repeat (4) @(posedge clock);
    #1 busy_flag = 1'b1;
    st(0, 0);
    op(OP_ULTRA, 8);
    st(0, 0);
    @(posedge clock) #1 busy_flag = 1'b0;
    op(OP_ULTRA, 12);
    st(0, 0);
    x = 8'($urandom);
    fr({OP_ULTRA, x, 32'h0}, 16);
    chk("busy", 16'h1, 16'(device_busy));
    wait_idle;
    st(1, 0);
    foreach (ign[i]) op(ign[i], 8);
    st(1, 0);
    op(OP_WAKE, 12);
    st(1, 0);
    r = n_rst;
    c = n_clr;
    op(OP_WAKE, 8);
    chk("sram_clear", 16'(c + 1), 16'(n_clr));
    chk("soft_reset", 16'(r + 1), 16'(n_rst));
    wait_idle;
    st(0, 0);
    @(posedge clock) #1 power_down_select = 1'b0;
    op(OP_DEEP, 8);
    wait_idle;
    st(1, 0);
    op(OP_WAKE, 8);
    wait_idle;
    @(posedge clock) #1 power_down_select = 1'b1;
    op(OP_DEEP, 8);
    wait_idle;
    st(0, 1);
    op(OP_ULTRA, 8);
    st(0, 1);
    op(OP_WAKE, 8);
    wait_idle;
    st(0, 0);
    op(OP_DEEP, 8);
    wait_idle;
    r = n_rst;
    op(OP_RESET_EN, 8);
    op(OP_RESET, 8);
    chk("soft_reset", 16'(r + 1), 16'(n_rst));
    wait_idle;
    st(0, 0);
    x = 8'($urandom);
    fr({OP_WAKE, x, 8'($urandom), ~x, 16'h0}, 48);
    chk("ident", {DEVICE_ID, DEVICE_ID}, i_fpr_host.rx_q);
    chk("so_oe", 16'h0, 16'(so_oe));
    r = n_rst;
    op(OP_RESET_EN, 8);
    op(8'h05, 8);
    op(OP_RESET, 8);
    chk("soft_reset", 16'(r), 16'(n_rst));
    op(OP_RESET_EN, 8);
    op(OP_RESET, 8);
    chk("soft_reset", 16'(r + 1), 16'(n_rst));
    chk("busy", 16'h1, 16'(device_busy));
    wait_idle;
    c = n_term;
    x = 8'($urandom);
    if (x == TERM_CONFIRM) x = 8'h00;
    fr({OP_TERMINATE, TERM_CONFIRM, 32'h0}, 16);
    chk("terminate", 16'(c), 16'(n_term));
    @(posedge clock) #1 terminate_permit = 1'b1;
    fr({OP_TERMINATE, x, 32'h0}, 16);
    chk("terminate", 16'(c), 16'(n_term));
    op(OP_TERMINATE, 8);
    chk("terminate", 16'(c), 16'(n_term));
    fr({OP_TERMINATE, TERM_CONFIRM, 32'h0}, 16);
    chk("terminate", 16'(c + 1), 16'(n_term));
    close_out;
  end
endmodule
`default_nettype wire
